// file: inc/svw_pkg.sv
/*
  Constants for the supervisor watchdog block: timebase, timeouts and
  the chip-select gate window. Assumes a 250 MHz system clock.
*/
package svw_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // internal timebase: one tick per millisecond at 250 MHz
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  // timeouts in internal ticks (ms)
  localparam logic [15:0] RST_TIMEOUT_MS = 16'h00C8;   // 200ms
  localparam logic [15:0] WD_SLOW_MS = 16'h0640;       // 1.6s
  localparam logic [15:0] WD_FAST_MS = 16'h0064;       // 100ms
  // external clock timeouts in external clocks
  localparam logic [15:0] EXT_WD_NORMAL = 16'h0400;    // 1024 clks
  localparam logic [15:0] EXT_WD_AFTER = 16'h1000;     // 4096 clks
  localparam logic [15:0] EXT_RST = 16'h0800;          // 2048 clks
  // chip-select grace after a reset assertion
  localparam int unsigned CS_GRACE_NS = 15000;
  localparam int unsigned CS_GRACE_CYC = CS_GRACE_NS / CLK_NS;
  localparam logic [15:0] CS_GRACE = 16'(CS_GRACE_CYC);
  // least kick pulse
  localparam int unsigned KICK_MIN_NS = 100;
  localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef enum logic [1:0] {
    SVW_ST_RESET = 2'b00,
    SVW_ST_RUN = 2'b01,
    SVW_ST_OFF = 2'b10
  } svw_state_type;
endpackage : svw_pkg

// file: rtl/svw_sync.sv
/*
  Two-flop synchroniser, one per bit, for pins entering mclk_in.
  Assumes nothing else reads the first stage.
*/
`timescale 1ns/100ps
module svw_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;
endmodule : svw_sync

// file: rtl/svw_top.sv
/*
  Supervisor: reset generation, watchdog, memory chip-select gate.
  Assumes analog comparisons (supply, backup, mid-level kick detect,
  power-fail) arrive as digital pins; all are synchronised here.
*/
// Summary of operation
// - supply low holds both resets; they stay asserted 200ms after recovery.
// - backup switchover never affects reset; backup implies supply low.
// - active-low reset plus open-drain active-high inverse reset.
// - kick level unchanged past watchdog timeout raises fault and reset.
// - any kick edge or 100ns pulse restarts the watchdog timer.
// - floating kick input disables the watchdog.
// - supply low disables watchdog and releases kick bias network.
// - fault flag high, watchdog off, when supply low, backup or floating.
// - timeout gives reset pulse, fault flag low until next kick edge.
// - a kick that never moves gives periodic reset pulses.
// - select and input high: internal, 1.6s watchdog, 200ms reset.
// - select high, input low: 100ms watchdog, 1.6s after reset.
// - external clock: 1024 normal, 4096 after reset, 2048 reset clocks.
// - select path passes while not in reset, disabled in reset.
// - on reset, path closes at select high or 15us, earliest.
// - at power-up the path stays closed until reset ends.
// - closed path releases the outgoing select to its pull-up; open drives it.
// - power-fail flag is independent of everything else.
// - supply-low output follows the supply indication three clocks later (two synchroniser flops, one register).
// - backup mode needs supply low and supply below backup.
// - backup-active output is high while on the backup supply.
`timescale 1ns/100ps
module svw_top
  import svw_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic supply_low_in,
  input wire logic below_backup_in,
  input wire logic wd_kick_in,
  input wire logic wd_kick_float_in,
  input wire logic timebase_select_in,
  input wire logic timebase_in,
  input wire logic powerfail_sense_in,
  input wire logic mem_cs_n_in,
  output logic rst_n_out,
  output logic rst_out,
  output logic rst_oe_out,
  output logic wd_fault_n_out,
  output logic wd_bias_en_out,
  output logic supply_low_n_out,
  output logic backup_active_out,
  output logic powerfail_flag_n_out,
  output logic mem_cs_n_out,
  output logic mem_cs_oe_out,
  output logic mem_cs_pull_out
);
  localparam int unsigned NSYNC = 8;

  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] sync_pins;
  logic supply_low_s;
  logic below_backup_s;
  logic kick_s;
  logic kick_float_s;
  logic tb_sel_s;
  logic tb_in_s;
  logic pf_sense_s;
  logic cs_n_s;

  assign raw_pins = {mem_cs_n_in, powerfail_sense_in, timebase_in,
                     timebase_select_in, wd_kick_float_in, wd_kick_in,
                     below_backup_in, supply_low_in};

  svw_sync #(.WIDTH(NSYNC)) u_sync (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  assign supply_low_s = sync_pins[0];
  assign below_backup_s = sync_pins[1];
  assign kick_s = sync_pins[2];
  assign kick_float_s = sync_pins[3];
  assign tb_sel_s = sync_pins[4];
  assign tb_in_s = sync_pins[5];
  assign pf_sense_s = sync_pins[6];
  assign cs_n_s = sync_pins[7];

  // timebase: 1ms tick, or rising edge of the external clock
  logic [17:0] div_q;
  logic [17:0] div_d;
  logic ms_tick;
  logic tb_prev_q;
  logic ext_tick;
  logic ext_mode;
  logic tick;

  assign ms_tick = (div_q == 18'(TICK_CYC - 1));
  assign div_d = ms_tick ? 18'h00000 : div_q + 18'h00001;
  assign ext_mode = !tb_sel_s;
  assign ext_tick = tb_in_s && !tb_prev_q;
  assign tick = ext_mode ? ext_tick : ms_tick;

  // modes and the limits they pick
  logic fast_mode;
  logic after_rst_q;
  logic [15:0] wd_limit;
  logic [15:0] rst_limit;

  assign fast_mode = tb_sel_s && !tb_in_s;
  assign wd_limit = ext_mode ? (after_rst_q ? EXT_WD_AFTER : EXT_WD_NORMAL)
                  : fast_mode ? (after_rst_q ? WD_SLOW_MS : WD_FAST_MS)
                  : WD_SLOW_MS;
  assign rst_limit = ext_mode ? EXT_RST : RST_TIMEOUT_MS;

  // backup mode and the watchdog enable
  logic backup_mode;
  logic wd_enabled;

  assign backup_mode = supply_low_s && below_backup_s;
  assign wd_enabled = !supply_low_s && !backup_mode && !kick_float_s;

  // kick edge detection; both edges count
  logic kick_prev_q;
  logic kick_edge;

  assign kick_edge = kick_s ^ kick_prev_q;

  // reset state machine
  svw_state_type st_q;
  svw_state_type st_d;
  logic [15:0] rst_cnt_q;
  logic [15:0] rst_cnt_d;
  logic [15:0] wd_cnt_q;
  logic [15:0] wd_cnt_d;
  logic wd_expire;
  logic fault_n_q;
  logic fault_n_d;
  logic in_reset;

  assign wd_expire = wd_enabled && (st_q == SVW_ST_RUN) && tick &&
                     !kick_edge && (wd_cnt_q >= wd_limit - ONE16);

  // supply low or backup holds reset; backup not consulted on its own
  always_comb begin
    st_d = st_q;
    rst_cnt_d = rst_cnt_q;
    case (st_q)
      SVW_ST_RESET: begin
        if (supply_low_s) begin
          rst_cnt_d = ZERO16;
        end else if (tick) begin
          if (rst_cnt_q >= rst_limit - ONE16) begin
            st_d = SVW_ST_RUN;
            rst_cnt_d = ZERO16;
          end else begin
            rst_cnt_d = rst_cnt_q + ONE16;
          end
        end
      end
      SVW_ST_RUN: begin
        if (supply_low_s || wd_expire) begin
          st_d = SVW_ST_RESET;
          rst_cnt_d = ZERO16;
        end
      end
      default: begin
        st_d = SVW_ST_RESET;
        rst_cnt_d = ZERO16;
      end
    endcase
  end

  assign in_reset = (st_q != SVW_ST_RUN);

  // watchdog counter restarts on any kick edge and during reset
  always_comb begin
    wd_cnt_d = wd_cnt_q;
    if (in_reset || !wd_enabled || kick_edge) begin
      wd_cnt_d = ZERO16;
    end else if (tick) begin
      wd_cnt_d = wd_cnt_q + ONE16;
    end
  end

  // fault flag: forced high when disabled, low from timeout to edge
  always_comb begin
    fault_n_d = fault_n_q;
    if (!wd_enabled) begin
      fault_n_d = 1'b1;
    end else if (wd_expire) begin
      fault_n_d = 1'b0;
    end else if (kick_edge) begin
      fault_n_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      st_q <= SVW_ST_RESET;
      rst_cnt_q <= ZERO16;
      wd_cnt_q <= ZERO16;
      fault_n_q <= 1'b1;
      div_q <= 18'h00000;
      tb_prev_q <= 1'b0;
      kick_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rst_cnt_q <= rst_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      fault_n_q <= fault_n_d;
      div_q <= div_d;
      tb_prev_q <= tb_in_s;
      kick_prev_q <= kick_s;
    end
  end

  // after-reset window: set by any reset, cleared by first kick edge
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      after_rst_q <= 1'b1;
    end else if (in_reset) begin
      after_rst_q <= 1'b1;
    end else if (kick_edge) begin
      after_rst_q <= 1'b0;
    end
  end

  // chip-select gate. a reset seen while select is low keeps the path
  // open for a grace window so a write cycle in flight can finish
  logic cs_open_q;
  logic cs_open_d;
  logic [15:0] grace_q;
  logic [15:0] grace_d;
  logic in_reset_q;
  logic rst_rise;
  logic grace_done;

  assign rst_rise = in_reset && !in_reset_q;
  assign grace_done = (grace_q >= CS_GRACE - ONE16);

  always_comb begin
    cs_open_d = cs_open_q;
    grace_d = grace_q;
    if (!in_reset) begin
      cs_open_d = 1'b1;
      grace_d = ZERO16;
    end else if (rst_rise) begin
      cs_open_d = cs_open_q && !cs_n_s;
      grace_d = ZERO16;
    end else if (cs_open_q) begin
      if (cs_n_s || grace_done) begin
        cs_open_d = 1'b0;
      end else begin
        grace_d = grace_q + ONE16;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cs_open_q <= 1'b0;
      grace_q <= ZERO16;
      in_reset_q <= 1'b1;
    end else begin
      cs_open_q <= cs_open_d;
      grace_q <= grace_d;
      in_reset_q <= in_reset;
    end
  end

  // outputs
  logic rst_n_q;
  logic pf_n_q;
  logic low_n_q;
  logic backup_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rst_n_q <= 1'b0;
      pf_n_q <= 1'b0;
      low_n_q <= 1'b0;
      backup_q <= 1'b0;
    end else begin
      rst_n_q <= !in_reset;
      pf_n_q <= pf_sense_s;
      low_n_q <= !supply_low_s;
      backup_q <= backup_mode;
    end
  end

  assign rst_n_out = rst_n_q;
  assign rst_out = 1'b0; // open drain: only ever pulls low
  assign rst_oe_out = rst_n_q;
  assign wd_fault_n_out = fault_n_q;
  assign wd_bias_en_out = !supply_low_s;
  assign supply_low_n_out = low_n_q;
  assign backup_active_out = backup_q;
  assign powerfail_flag_n_out = pf_n_q;
  // passing: the pin follows the registered input; closed: output high, released to the pull-up
  assign mem_cs_n_out = cs_open_q ? cs_n_s : 1'b1;
  assign mem_cs_oe_out = cs_open_q;
  assign mem_cs_pull_out = !cs_open_q;
endmodule : svw_top

// file: verification/svw_host_model.sv
/* Host model: free-running timebase clock and the kick line.
   Assumes mclk_in at 250 MHz; the kick moves only while run is high. */
`timescale 1ns/100ps
module svw_host_model (
  input wire logic mclk_in,
  input wire logic kick_run_in,
  output logic wd_kick_out,
  output logic timebase_out
);
  logic [9:0] cnt_q = 10'h000;
  initial wd_kick_out = 1'b0;
  initial timebase_out = 1'b0;
  // update on the edge itself: the bench drives run a step after the
  // edge, so sampling it here never races the bench
  always @(posedge mclk_in) begin
    cnt_q <= cnt_q + 10'h001;
    // two clocks per level, so each level survives the synchroniser
    timebase_out <= cnt_q[1];
    if (kick_run_in && cnt_q == 10'h000) begin
      wd_kick_out <= ~wd_kick_out;
    end
  end
endmodule : svw_host_model

// file: verification/svw_top_assertions.sv
/* Checker for svw_top: reset pair, fault flag, select gate.
   Assumes it is bound into svw_top and sees only its ports. */
`timescale 1ns/100ps
module svw_top_assertions (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic supply_low_in,
  input wire logic wd_kick_float_in,
  input wire logic powerfail_sense_in,
  input wire logic mem_cs_n_in,
  input wire logic rst_n_out,
  input wire logic rst_out,
  input wire logic rst_oe_out,
  input wire logic wd_fault_n_out,
  input wire logic supply_low_n_out,
  input wire logic powerfail_flag_n_out,
  input wire logic mem_cs_n_out,
  input wire logic mem_cs_oe_out,
  input wire logic mem_cs_pull_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic [12:0] grace_q;
  // how long the select path has stayed open into a reset
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || rst_n_out || !mem_cs_oe_out) begin
      grace_q <= 13'h0000;
    end else begin
      grace_q <= grace_q + 13'h0001;
    end
  end
  property p_pair; rst_oe_out == rst_n_out && rst_out == 1'b0; endproperty
  a_pair: assert property (p_pair) else $error("reset pair");
  property p_rst; supply_low_in [*5] |-> !rst_n_out; endproperty
  a_rst: assert property (p_rst) else $error("supply reset");
  property p_lown;
    $stable(supply_low_in) [*4] |-> supply_low_n_out != supply_low_in;
  endproperty
  a_lown: assert property (p_lown) else $error("low line");
  property p_fault;
    (supply_low_in || wd_kick_float_in) [*4] |-> wd_fault_n_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag");
  property p_pf;
    $stable(powerfail_sense_in) [*4] |->
      powerfail_flag_n_out == powerfail_sense_in;
  endproperty
  a_pf: assert property (p_pf) else $error("power-fail flag");
  // the reset pin is registered one edge behind the fault flag
  property p_wd; $fell(wd_fault_n_out) |=> !rst_n_out; endproperty
  a_wd: assert property (p_wd) else $error("fault without reset");
  property p_pull;
    mem_cs_pull_out != mem_cs_oe_out && (mem_cs_oe_out || mem_cs_n_out);
  endproperty
  a_pull: assert property (p_pull) else $error("select pull");
  property p_pass;
    rst_n_out [*5] ##0 $stable(mem_cs_n_in) [*3] |->
      mem_cs_oe_out && mem_cs_n_out == mem_cs_n_in;
  endproperty
  a_pass: assert property (p_pass) else $error("select pass");
  property p_grace; grace_q < 13'hEB0; endproperty
  a_grace: assert property (p_grace) else $error("select grace");
  c_wd: cover property ($fell(rst_n_out) && supply_low_n_out);
  c_rel: cover property ($rose(rst_n_out));
  c_gate: cover property ($fell(mem_cs_oe_out));
endmodule : svw_top_assertions
bind svw_top svw_top_assertions i_svw_top_assertions (.*);

// file: verification/test_svw_top.sv
/* Bench for svw_top in external-clock timebase mode.
   Assumes the host model supplies the timebase clock and kick line. */
`timescale 1ns/100ps
module test_svw_top;
  import svw_pkg::*;
  logic mclk_in = 1'b0, resetn_in = 1'b0, supply_low_in = 1'b0;
  logic below_backup_in = 1'b0, wd_kick_float_in = 1'b0;
  logic timebase_select_in = 1'b0, powerfail_sense_in = 1'b1;
  logic mem_cs_n_in = 1'b0, run = 1'b0, wd_kick_in, timebase_in, k;
  logic rst_n_out, rst_out, rst_oe_out, wd_fault_n_out, wd_bias_en_out;
  logic supply_low_n_out, backup_active_out, powerfail_flag_n_out;
  logic mem_cs_n_out, mem_cs_oe_out, mem_cs_pull_out;
  int err_total = 0, checked = 0, cyc = 0, n, i;
  // one timebase tick every four clocks
  localparam int TB = 4;
  svw_top i_svw_top (.*);
  svw_host_model i_svw_host_model (.mclk_in(mclk_in), .kick_run_in(run),
    .wd_kick_out(wd_kick_in), .timebase_out(timebase_in));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task step(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask : step
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic logic near(int a, int e);
    return a > e - 32 && a < e + 32;
  endfunction : near
  // clocks until reset reaches v, counted from the last kick edge
  task wait_rst(input logic v);
    n = 0;
    k = wd_kick_in;
    while (rst_n_out !== v && n < 40000) begin
      step(1);
      n++;
      if (wd_kick_in !== k) begin
        k = wd_kick_in;
        n = 0;
      end
    end
  endtask : wait_rst
  task close_out;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end
  initial begin
    step(12);
    resetn_in = 1'b1;
    step(20);
    chk(!rst_n_out && mem_cs_n_out && mem_cs_pull_out, "power-up");
    wait_rst(1'b1);
    chk(near(n, TB * EXT_RST - 20), "power-up width");
    step(4);
    chk(mem_cs_oe_out && mem_cs_n_out === 1'b0, "path open");
    mem_cs_n_in = 1'b1;
    step(4);
    chk(mem_cs_n_out === 1'b1, "select high");
    mem_cs_n_in = 1'b0;
    wait_rst(1'b0);
    chk(near(n, TB * EXT_WD_AFTER - 12), "first timeout");
    chk(!wd_fault_n_out && mem_cs_n_out === 1'b0, "fault");
    step(3760);
    chk(mem_cs_n_out && mem_cs_pull_out, "grace end");
    wait_rst(1'b1);
    chk(near(n, TB * EXT_RST - 3760), "fault reset");
    chk(wd_fault_n_out === 1'b0, "fault held");
    k = wd_kick_in;
    run = 1'b1;
    for (i = 0; i < 1100 && wd_kick_in === k; i++) begin
      step(1);
    end
    run = 1'b0;
    step(8);
    chk(wd_fault_n_out === 1'b1, "fault cleared");
    wait_rst(1'b0);
    chk(near(n, TB * EXT_WD_NORMAL - 8), "normal timeout");
    wait_rst(1'b1);
    chk(near(n, TB * EXT_RST), "repeat pulse");
    run = 1'b1;
    // longer than the after-reset timeout, so a lost kick edge shows
    step(18000);
    chk(rst_n_out === 1'b1, "kicked");
    run = 1'b0;
    wd_kick_float_in = 1'b1;
    below_backup_in = 1'b1;
    powerfail_sense_in = 1'b0;
    step(5000);
    chk(rst_n_out && wd_fault_n_out && !powerfail_flag_n_out, "float");
    chk(backup_active_out === 1'b0, "no backup");
    supply_low_in = 1'b1;
    step(6);
    chk(!rst_n_out && !supply_low_n_out && !wd_bias_en_out, "drop");
    chk(mem_cs_oe_out && backup_active_out, "drop gate");
    mem_cs_n_in = 1'b1;
    step(4);
    chk(mem_cs_n_out && mem_cs_pull_out, "closed");
    mem_cs_n_in = 1'b0;
    step(4);
    chk(mem_cs_n_out && wd_fault_n_out, "held closed");
    supply_low_in = 1'b0;
    powerfail_sense_in = 1'b1;
    step(6);
    chk(!backup_active_out && supply_low_n_out && wd_bias_en_out, "up");
    wait_rst(1'b1);
    chk(near(n, TB * EXT_RST - 6), "recovery");
    close_out();
  end
endmodule : test_svw_top
